// >>> acs_map.svh
// acs_map.svh: register offsets, field positions, reset values and timing counts
// assumes a 125 MHz system clock and a word-addressed Avalon-MM slave
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFS_SELECT      4'h0
`define ACS_OFS_CONTROL     4'h1
`define ACS_OFS_RESULT      4'h2
`define ACS_OFS_SYSTEM      4'h3
`define ACS_SEL_MUX_LSB     0
`define ACS_SEL_REF_LSB     6
`define ACS_CTL_PRESC_LSB   0
`define ACS_CTL_DONEIE      3
`define ACS_CTL_DONE        4
`define ACS_CTL_FREERUN     5
`define ACS_CTL_START       6
`define ACS_CTL_ENABLE      7
`define ACS_SELECT_RESET    8'h00
`define ACS_CONTROL_RESET   8'h00
`define ACS_NORMAL_CYCLES   5'h0d
`define ACS_FIRST_CYCLES    5'h19
`define ACS_FULL_SCALE      10'h3ff
`endif

// >>> acs_pkg.sv
// acs_pkg.sv: types shared by the sequencer
// assumes nothing beyond a SystemVerilog compiler
package acs_pkg;
    // conversion sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_ARMED,
        ACS_CONVERT
    } acs_state_type;
    // sleep mode requested by the cpu
    typedef enum logic [2:0] {
        ACS_SLEEP_NONE,
        ACS_SLEEP_IDLE,
        ACS_SLEEP_NOISE,
        ACS_SLEEP_OTHER
    } acs_sleep_type;
endpackage : acs_pkg

// >>> acs_prescaler.sv
// acs_prescaler.sv: converter clock enable from the system clock
// assumes enable comes from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic [2:0] divSelect,
    output logic            tick
);
    logic [6:0] count;      // free counter
    logic [6:0] next_count; // next counter value
    logic       next_tick;  // next pulse
    logic [6:0] limit;      // terminal value

    // divide by 2 to 128; held clear while disabled
    always_comb begin
        limit = 7'h7f >> (3'h7 - ((divSelect == 3'h0) ? 3'h1 : divSelect));
        next_count = count + 7'h01;
        next_tick = 1'b0;
        if (!enable) begin
            next_count = 7'h00;
        end else if (count >= limit) begin
            next_count = 7'h00;
            next_tick = 1'b1;
        end
    end

    // register the counter and the pulse
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 7'h00;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : acs_prescaler
`default_nettype wire

// >>> acs_sequencer.sv
// acs_sequencer.sv: channel/reference buffering and conversion sequencing
// assumes an Avalon-MM master on clock, analog path and sleep pins outside
// Behaviour
// - shadow selection register always writable
// - applied follows shadow until conversion starts
// - copying resumes in final converter cycle
// - start waits for next converter tick
// - test port disables upper four channels
// - free-run next conversion keeps old channel
// - over-reference single-ended input saturates full scale
// - quiet sleep starts a conversion automatically; here only with DONEIE set and free run off
// - completion raises interrupt request, waking cpu
// - other sleep modes keep converter enabled
// - same input allowed on both differential inputs
// - selection reaches analog path only when enabled
// - completion writes result, sets done, clears start except in free run
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_sequencer (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [3:0]             avsAddress,
    input  wire logic                   avsRead,
    input  wire logic                   avsWrite,
    input  wire logic [31:0]            avsWriteData,
    output logic [31:0]                 avsReadData,
    output logic                        avsWaitRequest,
    input  wire acs_pkg::acs_sleep_type sleepMode,
    input  wire logic                   cpuHalted,
    input  wire logic                   testPortEnable,
    input  wire logic                   compareHigh,
    output logic [4:0]                  channelGainSelect,
    output logic [1:0]                  referenceSelect,
    output logic                        analogEnable,
    output logic                        sampleHold,
    output logic                        conversionIrq
);
    logic [7:0]  shadowSel;       // cpu-visible selection
    logic [7:0]  appliedSel;      // selection in the analog path
    logic [7:0]  control;         // control/status bits
    logic [9:0]  result;          // last result
    logic [9:0]  sar;             // approximation register
    logic [4:0]  cycles;          // converter cycles into conversion
    logic        firstConv;       // next conversion is the long one
    logic        ackPending;      // one-cycle bus answer
    logic [1:0]  halt;            // halt synchroniser
    logic [1:0]  cmp;             // comparator synchroniser
    logic [1:0]  test;            // test port synchroniser
    logic        haltSeen;        // halt already used for a start
    acs_pkg::acs_state_type state;
    logic [7:0]  next_shadowSel;
    logic [7:0]  next_appliedSel;
    logic [7:0]  next_control;
    logic [9:0]  next_result;
    logic [9:0]  next_sar;
    logic [4:0]  next_cycles;
    logic        next_firstConv;
    logic        next_ackPending;
    logic        next_haltSeen;
    acs_pkg::acs_state_type next_state;
    logic        tick;            // converter clock enable
    logic        busWrite;        // accepted write
    logic [4:0]  total;           // length of this conversion
    logic        lastCycle;       // final converter cycle
    logic        quietSleep;      // sleep that allows noise canceling

    // bus answers one cycle after the request
    assign busWrite = avsWrite && ackPending;
    assign avsWaitRequest = (avsRead || avsWrite) && !ackPending;
    assign total = firstConv ? `ACS_FIRST_CYCLES : `ACS_NORMAL_CYCLES;
    assign lastCycle = (state == acs_pkg::ACS_CONVERT) && (cycles == total - 5'h01);
    assign quietSleep = (sleepMode == acs_pkg::ACS_SLEEP_IDLE)
                     || (sleepMode == acs_pkg::ACS_SLEEP_NOISE);

    // channel is usable unless the test port owns the upper pins
    function automatic logic channelBlocked(input logic [4:0] mux, input logic tp);
        channelBlocked = tp && (mux[4:2] == 3'h1);
    endfunction : channelBlocked

    // converter clock divider
    acs_prescaler prescaler (
        .clock     (clock),
        .rst       (rst),
        .enable    (control[`ACS_CTL_ENABLE]),
        .divSelect (control[`ACS_CTL_PRESC_LSB +: 3]),
        .tick      (tick)
    );

    // pin synchronisers
    always_ff @(posedge clock) begin
        if (rst) begin
            halt <= 2'h0;
            cmp <= 2'h0;
            test <= 2'h0;
        end else begin
            halt <= {halt[0], cpuHalted};
            cmp <= {cmp[0], compareHigh};
            test <= {test[0], testPortEnable};
        end
    end

    // next values for registers and sequencer
    always_comb begin
        next_shadowSel = shadowSel;
        next_appliedSel = appliedSel;
        next_control = control;
        next_result = result;
        next_sar = sar;
        next_cycles = cycles;
        next_firstConv = firstConv;
        next_ackPending = (avsRead || avsWrite) && !ackPending;
        next_haltSeen = halt[1] ? haltSeen : 1'b0;
        next_state = state;
        // register writes; the shadow is always writable
        if (busWrite && avsAddress == `ACS_OFS_SELECT) begin
            next_shadowSel = avsWriteData[7:0];
        end
        if (busWrite && avsAddress == `ACS_OFS_CONTROL) begin
            next_control = avsWriteData[7:0];
            // start bit cannot be cleared by writing zero
            next_control[`ACS_CTL_START] = avsWriteData[`ACS_CTL_START]
                                        || control[`ACS_CTL_START];
            // writing one clears the done flag
            next_control[`ACS_CTL_DONE] = control[`ACS_CTL_DONE]
                                       && !avsWriteData[`ACS_CTL_DONE];
        end
        // automatic start in quiet sleep
        if (quietSleep && halt[1] && !haltSeen && control[`ACS_CTL_ENABLE]
            && state == acs_pkg::ACS_IDLE && !control[`ACS_CTL_START]
            && !control[`ACS_CTL_FREERUN] && control[`ACS_CTL_DONEIE]) begin
            next_control[`ACS_CTL_START] = 1'b1;
            next_haltSeen = 1'b1;
        end
        // applied selection tracks the shadow when unlocked
        if (state != acs_pkg::ACS_CONVERT || lastCycle) begin
            next_appliedSel = shadowSel;
        end
        case (state)
            acs_pkg::ACS_IDLE: begin
                if (control[`ACS_CTL_START] && control[`ACS_CTL_ENABLE]) begin
                    next_state = acs_pkg::ACS_ARMED;
                end
            end
            acs_pkg::ACS_ARMED: begin
                if (tick) begin
                    next_state = acs_pkg::ACS_CONVERT;
                    next_cycles = 5'h00;
                    next_sar = 10'h000;
                end
            end
            acs_pkg::ACS_CONVERT: begin
                if (tick) begin
                    next_cycles = cycles + 5'h01;
                    // one bit decided per cycle after sampling
                    if (cycles >= total - 5'h0b && cycles < total - 5'h01) begin
                        next_sar = {sar[8:0], cmp[1]};
                    end
                    if (lastCycle) begin
                        next_result = channelBlocked(appliedSel[4:0], test[1])
                                    ? 10'h000 : next_sar;
                        next_control[`ACS_CTL_DONE] = 1'b1;
                        next_firstConv = 1'b0;
                        next_cycles = 5'h00;
                        next_sar = 10'h000;
                        if (control[`ACS_CTL_FREERUN]) begin
                            // immediate restart on the old applied channel
                            next_state = acs_pkg::ACS_CONVERT;
                        end else begin
                            next_control[`ACS_CTL_START] = 1'b0;
                            next_state = acs_pkg::ACS_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_state = acs_pkg::ACS_IDLE;
            end
        endcase
        // disabling aborts and forces a long first conversion
        if (!control[`ACS_CTL_ENABLE]) begin
            next_state = acs_pkg::ACS_IDLE;
            next_firstConv = 1'b1;
            next_control[`ACS_CTL_START] = 1'b0;
        end
    end

    // register all sequencer state
    always_ff @(posedge clock) begin
        if (rst) begin
            shadowSel <= `ACS_SELECT_RESET;
            appliedSel <= `ACS_SELECT_RESET;
            control <= `ACS_CONTROL_RESET;
            result <= 10'h000;
            sar <= 10'h000;
            cycles <= 5'h00;
            firstConv <= 1'b1;
            ackPending <= 1'b0;
            haltSeen <= 1'b0;
            state <= acs_pkg::ACS_IDLE;
        end else begin
            shadowSel <= next_shadowSel;
            appliedSel <= next_appliedSel;
            control <= next_control;
            result <= next_result;
            sar <= next_sar;
            cycles <= next_cycles;
            firstConv <= next_firstConv;
            ackPending <= next_ackPending;
            haltSeen <= next_haltSeen;
            state <= next_state;
        end
    end

    // read data and analog outputs, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            avsReadData <= 32'h0000_0000;
            channelGainSelect <= 5'h00;
            referenceSelect <= 2'h0;
            analogEnable <= 1'b0;
            sampleHold <= 1'b0;
            conversionIrq <= 1'b0;
        end else begin
            case (avsAddress)
                `ACS_OFS_SELECT:  avsReadData <= {24'h000000, shadowSel};
                `ACS_OFS_CONTROL: avsReadData <= {24'h000000, control};
                `ACS_OFS_RESULT:  avsReadData <= {22'h000000, result};
                `ACS_OFS_SYSTEM:  avsReadData <= {27'h0000000, firstConv, 2'h0, state};
                default:          avsReadData <= 32'h0000_0000;
            endcase
            // selection only reaches the path while enabled
            analogEnable <= control[`ACS_CTL_ENABLE];
            channelGainSelect <= control[`ACS_CTL_ENABLE] ? appliedSel[4:0] : 5'h00;
            referenceSelect <= control[`ACS_CTL_ENABLE]
                             ? appliedSel[`ACS_SEL_REF_LSB +: 2] : 2'h0;
            sampleHold <= (state == acs_pkg::ACS_CONVERT)
                       && (cycles <= (firstConv ? 5'h0d : 5'h01));
            conversionIrq <= next_control[`ACS_CTL_DONE] && next_control[`ACS_CTL_DONEIE];
        end
    end

    // checks
    chk_lock_applied: assert property (@(posedge clock) disable iff (rst)
        (state == acs_pkg::ACS_CONVERT && !lastCycle) |=> $stable(appliedSel))
        else $error("applied selection changed while locked");
    chk_track_idle: assert property (@(posedge clock) disable iff (rst)
        (state == acs_pkg::ACS_IDLE) |=> (appliedSel == $past(shadowSel)))
        else $error("applied selection not tracking");
    chk_resume_last: assert property (@(posedge clock) disable iff (rst)
        lastCycle |=> (appliedSel == $past(shadowSel)))
        else $error("no update in final cycle");
    chk_start_tick: assert property (@(posedge clock) disable iff (rst)
        (state == acs_pkg::ACS_ARMED && !tick && control[`ACS_CTL_ENABLE])
        |=> (state == acs_pkg::ACS_ARMED))
        else $error("conversion started without tick");
    chk_done_clear: assert property (@(posedge clock) disable iff (rst)
        (lastCycle && tick && !control[`ACS_CTL_FREERUN] && control[`ACS_CTL_ENABLE])
        |=> (control[`ACS_CTL_DONE] && !control[`ACS_CTL_START]))
        else $error("completion did not set done and clear start");
    chk_freerun_go: assert property (@(posedge clock) disable iff (rst)
        (lastCycle && tick && control[`ACS_CTL_FREERUN] && control[`ACS_CTL_ENABLE])
        |=> (state == acs_pkg::ACS_CONVERT && cycles == 5'h00))
        else $error("free run did not restart");
    chk_shadow_keep: assert property (@(posedge clock) disable iff (rst)
        (busWrite && avsAddress == `ACS_OFS_SELECT) |=> (shadowSel == $past(avsWriteData[7:0])))
        else $error("shadow write lost");
    chk_path_off: assert property (@(posedge clock) disable iff (rst)
        !control[`ACS_CTL_ENABLE] |=> (channelGainSelect == 5'h00 && !analogEnable))
        else $error("selection applied while disabled");
    chk_irq_done: assert property (@(posedge clock) disable iff (rst)
        (control[`ACS_CTL_DONE] && control[`ACS_CTL_DONEIE]) |-> conversionIrq)
        else $error("interrupt request missing");
    chk_bus_answer: assert property (@(posedge clock) disable iff (rst)
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("bus answer late");
    cov_single: cover property (@(posedge clock) disable iff (rst)
        lastCycle && tick && !control[`ACS_CTL_FREERUN]);
    cov_freerun: cover property (@(posedge clock) disable iff (rst)
        lastCycle && tick && control[`ACS_CTL_FREERUN]);
    cov_sleep: cover property (@(posedge clock) disable iff (rst) next_haltSeen && !haltSeen);
    cov_locked_write: cover property (@(posedge clock) disable iff (rst)
        busWrite && avsAddress == `ACS_OFS_SELECT && state == acs_pkg::ACS_CONVERT);
    cov_blocked: cover property (@(posedge clock) disable iff (rst)
        lastCycle && tick && test[1]);
    // blocked inputs, other sleeps and the sample window
    chk_blocked_zero: assert property (@(posedge clock) disable iff (rst)
        (lastCycle && tick && control[`ACS_CTL_ENABLE]
         && channelBlocked(appliedSel[4:0], test[1])) |=> (result == 10'h000))
        else $error("blocked channel gave a result");
    chk_sleep_keep: assert property (@(posedge clock) disable iff (rst)
        (sleepMode == acs_pkg::ACS_SLEEP_OTHER && control[`ACS_CTL_ENABLE] && !busWrite)
        |=> control[`ACS_CTL_ENABLE])
        else $error("converter disabled by sleep");
    chk_other_nostart: assert property (@(posedge clock) disable iff (rst)
        (sleepMode == acs_pkg::ACS_SLEEP_OTHER && state == acs_pkg::ACS_IDLE
         && !control[`ACS_CTL_START] && !busWrite) |=> !control[`ACS_CTL_START])
        else $error("conversion started in a loud sleep");
    chk_hold_convert: assert property (@(posedge clock) disable iff (rst)
        sampleHold |-> ($past(state) == acs_pkg::ACS_CONVERT))
        else $error("sample taken outside a conversion");
endmodule : acs_sequencer
`default_nettype wire

// >>> acs_analog_model.sv
// acs_analog_model.sv: comparator stand-in for the analog mux, gain stage and sample-and-hold
// assumes the sequencer's selection outputs and a bench-set mask of inputs above reference
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
    input  wire logic [4:0]  channelGainSelect, // applied channel from the sequencer
    input  wire logic        analogEnable,      // analog path powered
    input  wire logic [31:0] highMask,          // inputs driven above reference
    output logic             compareHigh        // comparator decision
);
    // selected input above reference answers high on every bit, others sit at ground
    always_comb begin
        compareHigh = analogEnable & highMask[channelGainSelect];
    end
endmodule : acs_analog_model
`default_nettype wire

// >>> testbench.sv
// testbench.sv: directed tests of the conversion sequencer over its Avalon-MM slave
// assumes acs_pkg compiled first and acs_map.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module testbench;
    logic                  clock          = 1'b0;
    logic                  rst            = 1'b1;
    logic [3:0]            avsAddress     = 4'h0;
    logic                  avsRead        = 1'b0;
    logic                  avsWrite       = 1'b0;
    logic [31:0]           avsWriteData   = 32'h0;
    logic [31:0]           avsReadData;
    logic                  avsWaitRequest;
    acs_pkg::acs_sleep_type sleepMode     = acs_pkg::ACS_SLEEP_NONE;
    logic                  cpuHalted      = 1'b0;
    logic                  testPortEnable = 1'b0;
    logic                  compareHigh;
    logic [4:0]            channelGainSelect;
    logic [1:0]            referenceSelect;
    logic                  analogEnable;
    logic                  conversionIrq;
    logic                  sampleHold;
    logic                  holdSeen       = 1'b0;  // sample window seen
    logic [31:0]           highMask       = 32'h0; // inputs above reference
    logic [31:0]           rd;                     // last read data
    int                    nMismatch      = 0;
    int                    nCompared      = 0;
    int                    cycles         = 0;

    // free-running 125 MHz clock
    always #4 clock = ~clock;

    acs_sequencer uut (.clock(clock), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .sleepMode(sleepMode), .cpuHalted(cpuHalted),
        .testPortEnable(testPortEnable), .compareHigh(compareHigh),
        .channelGainSelect(channelGainSelect), .referenceSelect(referenceSelect),
        .analogEnable(analogEnable), .sampleHold(sampleHold), .conversionIrq(conversionIrq));

    acs_analog_model model (.channelGainSelect(channelGainSelect), .analogEnable(analogEnable),
        .highMask(highMask), .compareHigh(compareHigh));

    // verdict and end of run
    task print_verdict;
        if (nMismatch == 0 && nCompared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // word compare
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpWord

    // single flag compare
    task automatic cmpBit(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpBit

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            print_verdict();
        end
    end

    // sticky record of the sample-and-hold window
    always @(posedge clock) begin
        if (sampleHold === 1'b1) holdSeen <= 1'b1;
    end

    // one bus access: raise after an edge, hold until waitrequest sampled low, then release
    task automatic avAccess(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avsAddress   <= a;
        avsWriteData <= d;
        avsWrite     <= wr;
        avsRead      <= !wr;
        @(posedge clock);
        while (avsWaitRequest !== 1'b0) @(posedge clock);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask : avAccess

    task automatic avWrite(input logic [3:0] a, input logic [31:0] d);
        avAccess(1'b1, a, d);
    endtask : avWrite

    task automatic avRead(input logic [3:0] a);
        avAccess(1'b0, a, 32'h0);
    endtask : avRead

    // poll the done flag, bounded
    task automatic waitDone;
        int n;
        n  = 0;
        rd = 32'h0;
        while (rd[`ACS_CTL_DONE] !== 1'b1 && n < 300) begin
            avRead(`ACS_OFS_CONTROL);
            n++;
        end
    endtask : waitDone

    // main sequence
    initial begin
        int t;
        int n;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        avRead(`ACS_OFS_SELECT);
        cmpWord(rd, 32'h0);
        avRead(`ACS_OFS_CONTROL);
        cmpWord(rd, 32'h0);
        avRead(4'hf);
        cmpWord(rd, 32'h0);
        // single-ended inputs only, so no gain-stage settling applies
        avWrite(`ACS_OFS_SELECT, 32'h41);
        avRead(`ACS_OFS_SELECT);
        cmpWord(rd, 32'h41);
        @(negedge clock);
        cmpWord({25'h0, referenceSelect, channelGainSelect}, 32'h0);
        avWrite(`ACS_OFS_CONTROL, 32'h81);
        highMask <= 32'h22;
        repeat (3) @(posedge clock);
        @(negedge clock);
        cmpWord({25'h0, referenceSelect, channelGainSelect}, 32'h21);
        // first result after the reference switch is thrown away
        avWrite(`ACS_OFS_CONTROL, 32'hc9);
        waitDone();
        avWrite(`ACS_OFS_CONTROL, 32'h99);
        // single conversion on a saturated input
        avWrite(`ACS_OFS_CONTROL, 32'hc9);
        waitDone();
        cmpWord(rd, 32'h99);
        avRead(`ACS_OFS_RESULT);
        cmpWord(rd, {22'h0, `ACS_FULL_SCALE});
        @(negedge clock);
        cmpBit(conversionIrq, 1'b1);
        avWrite(`ACS_OFS_CONTROL, 32'h99);
        // shadow write during lock is held back then applied
        avWrite(`ACS_OFS_SELECT, 32'h42);
        avWrite(`ACS_OFS_CONTROL, 32'hc9);
        repeat (4) @(posedge clock);
        avWrite(`ACS_OFS_SELECT, 32'h41);
        @(negedge clock);
        cmpWord({27'h0, channelGainSelect}, 32'h2);
        avRead(`ACS_OFS_SELECT);
        cmpWord(rd, 32'h41);
        waitDone();
        avRead(`ACS_OFS_RESULT);
        cmpWord(rd, 32'h0);
        @(negedge clock);
        cmpWord({27'h0, channelGainSelect}, 32'h1);
        avWrite(`ACS_OFS_CONTROL, 32'h99);
        // upper channel blocked while test port is on
        avWrite(`ACS_OFS_SELECT, 32'h45);
        for (t = 1; t >= 0; t--) begin
            testPortEnable <= t[0];
            repeat (4) @(posedge clock);
            avWrite(`ACS_OFS_CONTROL, 32'hc9);
            waitDone();
            avRead(`ACS_OFS_RESULT);
            cmpWord(rd, (t == 1) ? 32'h0 : 32'h3ff);
            avWrite(`ACS_OFS_CONTROL, 32'h99);
        end
        // free run: change after completion shows one result late
        avWrite(`ACS_OFS_SELECT, 32'h41);
        avWrite(`ACS_OFS_CONTROL, 32'he1);
        waitDone();
        avWrite(`ACS_OFS_SELECT, 32'h42);
        avWrite(`ACS_OFS_CONTROL, 32'hb1);
        waitDone();
        avRead(`ACS_OFS_RESULT);
        cmpWord(rd, 32'h3ff);
        avWrite(`ACS_OFS_CONTROL, 32'hb1);
        waitDone();
        avRead(`ACS_OFS_RESULT);
        cmpWord(rd, 32'h0);
        avWrite(`ACS_OFS_CONTROL, 32'h00);
        avWrite(`ACS_OFS_CONTROL, 32'h99);
        // quiet sleeps start a conversion that raises the request
        for (t = 0; t < 2; t++) begin
            sleepMode <= (t == 0) ? acs_pkg::ACS_SLEEP_IDLE : acs_pkg::ACS_SLEEP_NOISE;
            cpuHalted <= 1'b1;
            n = 0;
            do begin
                @(negedge clock);
                n++;
            end while (conversionIrq !== 1'b1 && n < 400);
            cmpBit(conversionIrq, 1'b1);
            @(posedge clock);
            cpuHalted <= 1'b0;
            sleepMode <= acs_pkg::ACS_SLEEP_NONE;
            avWrite(`ACS_OFS_CONTROL, 32'h99);
        end
        // other sleep: no auto start, converter left on
        sleepMode <= acs_pkg::ACS_SLEEP_OTHER;
        cpuHalted <= 1'b1;
        repeat (200) @(posedge clock);
        @(negedge clock);
        cmpBit(conversionIrq, 1'b0);
        cmpBit(analogEnable, 1'b1);
        cmpBit(holdSeen, 1'b1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
